// ### inc/lsq_pkg.sv
`default_nettype none
package lsq_pkg;
  // Clock and timing base.
  localparam int CLK_PERIOD_PS = 4000;
  localparam int US_PS = 1000000;
  localparam int CYC_PER_US = US_PS / CLK_PERIOD_PS;
  localparam int N_CH = 4;
  localparam int AW = 14;
  // Durations in microseconds.
  localparam logic [30:0] MIN_WIDTH_US = 31'h0000_0064;
  localparam logic [30:0] MAX_TIME_US = 31'h7735_9400;
  localparam logic [30:0] DEF_FRAME_US = 31'h0000_61A8;
  localparam logic [30:0] DEF_STROBE_US = 31'h0000_4E20;
  localparam logic [30:0] DEF_CAM_US = 31'h0000_3A98;
  localparam logic [3:0] DEF_FRAMES = 4'h4;
  // Trigger delay limits, in units of the selected step.
  localparam logic [15:0] DLY_MIN = 16'h0002;
  localparam logic [15:0] DLY_MAX_US = 16'hFDE8;
  localparam logic [15:0] DLY_MAX_MS = 16'h3E80;
  localparam logic [9:0] US_PER_MS = 10'h3E8;
  // Program storage limits.
  localparam logic [2:0] MAX_RECIPES = 3'h6;
  localparam logic [3:0] MAX_SEQS = 4'hA;
  localparam logic [3:0] MAX_FRAMES = 4'hC;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DELAY = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PADDR = 8'h0C;
  localparam logic [7:0] OFS_PDATA = 8'h10;
  // Control register fields and reset values.
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_EVT_LSB = 2;
  localparam int CTRL_DLYEN_BIT = 4;
  localparam int CTRL_DLYMS_BIT = 5;
  localparam int CTRL_DEF_BIT = 6;
  localparam int CTRL_RCP_LSB = 8;
  localparam logic [1:0] TYPE_ONESHOT = 2'h0;
  localparam logic [1:0] TYPE_CONT = 2'h1;
  localparam logic [1:0] TYPE_FREE = 2'h2;
  localparam logic [1:0] EVT_RECIPE = 2'h0;
  localparam logic [1:0] EVT_SEQ = 2'h1;
  localparam logic [1:0] EVT_FRAME = 2'h2;
  localparam logic RST_USE_DEF = 1'b1;
  // Status register fields.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DLY_BIT = 1;
  localparam int STAT_SEQ_LSB = 4;
  localparam int STAT_FRM_LSB = 8;
  localparam int STAT_REP_LSB = 16;
  localparam int STAT_LED_LSB = 24;
  localparam int STAT_CAM_BIT = 28;
  // Program word fields: address is {recipe, sequence, frame, field}.
  localparam logic [2:0] FLD_FRAME = 3'h0;
  localparam logic [2:0] FLD_STROBE0 = 3'h1;
  localparam logic [2:0] FLD_CAM = 3'h5;
  localparam logic [2:0] FLD_SEQHDR = 3'h6;
  localparam logic [2:0] FLD_RCPHDR = 3'h7;
  localparam int HDR_CNT_LSB = 0;
  localparam int HDR_REP_LSB = 8;
  localparam logic [2:0] LAST_STEP = 3'h7;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_FETCH, ST_RUN} lsq_state_t;

  typedef struct packed {
    lsq_state_t st;
    logic [1:0] typ;
    logic [1:0] evt;
    logic dly_en;
    logic dly_ms;
    logic use_def;
    logic [2:0] rcp;
    logic [15:0] dly;
    logic [AW-1:0] paddr;
    logic ph_act;
    logic ph_wr;
    logic [7:0] ph_a;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [2:0] sync;
    logic [2:0] step;
    logic [AW-1:0] pa;
    logic [3:0] seq;
    logic [3:0] frm;
    logic [3:0] nseq;
    logic [3:0] nfrm;
    logic [7:0] rep;
    logic [7:0] nrep;
    logic [30:0] ftime;
    logic [30:0] cw;
    logic [30:0] el;
    logic [N_CH-1:0][30:0] sw;
    logic [15:0] dcnt;
    logic [9:0] msub;
    logic [N_CH-1:0] leds;
    logic cam;
  } lsq_eng_t;
endpackage
`default_nettype wire

// ### hdl/lsq_tick.sv
`timescale 1ns/100ps
`default_nettype none
module lsq_tick
  import lsq_pkg::*;
#(
  parameter int DIV = CYC_PER_US
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Restart and tick
  input wire logic clr,
  output logic tick
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_r, cnt_nxt;

  // One pulse per microsecond; clr restarts the count so frames start on a whole tick.
  assign tick = (cnt_r == CW'(DIV - 1)) && !clr;

  // Next count.
  always_comb begin
    cnt_nxt = (clr || tick) ? '0 : CW'(cnt_r + 1'b1);
  end

  // Count register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Ticks are never closer than the divider allows.
  property p_tick_gap;
    @(posedge clk) disable iff (!rst_n) tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("Tick pulses too close.");
endmodule
`default_nettype wire

// ### hdl/lsq_prog_mem.sv
`timescale 1ns/100ps
`default_nettype none
module lsq_prog_mem #(
  parameter int AW = 14,
  parameter int DW = 32
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1 << AW) - 1];

  // Simple dual port store with registered read data.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// ### hdl/lsq_top.sv
// Contract
// - Default program is one sequence of four frames for photometric imaging.
// - Default timing: 25 ms frame, 20 ms strobe, 15 ms camera pulse.
// - Triggers up to ten thousand per second; source spaces them 100 us apart.
// - Every generated pulse lasts at least 100 us.
// - Without delay, first frame starts within 50 us of a trigger.
// - All durations are timed in whole microseconds.
// - Skew and jitter between output channel edges stay within 10 us.
// - Each frame has its own duration from 100 us to 2000 s.
// - Each channel strobe width is 100 us to 2000 s, below frame time.
// - Camera pulse width is 100 us to 2000 s, below frame time.
// - Trigger types: one-shot by default, continuous, and free-run.
// - One-shot triggers advance by a recipe, a sequence or a frame.
// - Optional trigger delay, 2 us to 65 ms in us or 2 ms to 16 s in ms.
// - Storage holds six recipes, ten sequences each, twelve frames each.
// - Recipe event: a trigger runs the whole recipe, then waits idle.
// - Sequence event: a trigger runs the next sequence, wrapping after the last.
// - Frame event: a trigger runs one frame, wrapping after the final frame.
// - Continuous: recipe repeats while trigger is active, finishes when it drops.
`timescale 1ns/100ps
`default_nettype none
module lsq_top
  import lsq_pkg::*;
#(
  parameter int DIV = CYC_PER_US
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Trigger in, lighting and camera out
  input wire logic trig_in,
  output logic [N_CH-1:0] lighting_channel_outputs,
  output logic cam_trig_out
);
  lsq_eng_t s_r, s_nxt;
  logic tick, tick_clr, lvl, rise, go, mem_we;
  logic last_frm, last_rep, last_seq, seq_done, rcp_done, keep;
  logic [31:0] mem_rd, d;
  logic [15:0] dlim;

  // Address of the program word fetched at a given step.
  function automatic logic [AW-1:0] addr_of(input logic [2:0] step, input logic [2:0] rcp,
                                            input logic [3:0] seq, input logic [3:0] frm);
    logic [AW-1:0] a;
    case (step)
      3'h0: a = {rcp, 4'h0, 4'h0, FLD_RCPHDR};
      3'h1: a = {rcp, seq, 4'h0, FLD_SEQHDR};
      default: a = {rcp, seq, frm, 3'(step - 3'h2)};
    endcase
    return a;
  endfunction

  // Built-in program: channel k lights in frame k of a single sequence.
  function automatic logic [31:0] dflt_val(input logic [AW-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a[2:0])
      FLD_RCPHDR: v[HDR_CNT_LSB +: 4] = 4'h1;
      FLD_SEQHDR: v = {16'h0000, 8'h01, 4'h0, DEF_FRAMES};
      FLD_FRAME: v = {1'b0, DEF_FRAME_US};
      FLD_CAM: v = {1'b0, DEF_CAM_US};
      default: begin
        if ({1'b0, a[6:3]} == 5'(a[2:0] - FLD_STROBE0)) begin
          v = {1'b0, DEF_STROBE_US};
        end
      end
    endcase
    return v;
  endfunction

  // Pulse width: off when zero, at least the minimum, strictly below the frame.
  function automatic logic [30:0] clamp_w(input logic [30:0] w, input logic [30:0] f);
    logic [30:0] r;
    r = (w != '0 && w < MIN_WIDTH_US) ? MIN_WIDTH_US : w;
    if (r >= f) begin
      r = 31'(f - 31'h1);
    end
    if (r != '0 && r < MIN_WIDTH_US) begin
      r = '0;
    end
    return r;
  endfunction

  // Count from a header: zero means one, and the storage limit caps it.
  function automatic logic [3:0] cnt_clamp(input logic [3:0] v, input logic [3:0] lim);
    return (v == 4'h0) ? 4'h1 : ((v > lim) ? lim : v);
  endfunction

  // Start a program fetch at the current position.
  function automatic lsq_eng_t begin_fetch(input lsq_eng_t e);
    e.st = ST_FETCH;
    e.step = 3'h0;
    e.pa = addr_of(3'h0, e.rcp, e.seq, e.frm);
    return e;
  endfunction

  // Register read view.
  function automatic logic [31:0] rd_mux(input logic [7:0] a, input lsq_eng_t e);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      OFS_CTRL: begin
        r[CTRL_TYPE_LSB +: 2] = e.typ;
        r[CTRL_EVT_LSB +: 2] = e.evt;
        r[CTRL_DLYEN_BIT] = e.dly_en;
        r[CTRL_DLYMS_BIT] = e.dly_ms;
        r[CTRL_DEF_BIT] = e.use_def;
        r[CTRL_RCP_LSB +: 3] = e.rcp;
      end
      OFS_DELAY: r[15:0] = e.dly;
      OFS_STATUS: begin
        r[STAT_BUSY_BIT] = (e.st != ST_IDLE);
        r[STAT_DLY_BIT] = (e.st == ST_DELAY);
        r[STAT_SEQ_LSB +: 4] = e.seq;
        r[STAT_FRM_LSB +: 4] = e.frm;
        r[STAT_REP_LSB +: 8] = e.rep;
        r[STAT_LED_LSB +: N_CH] = e.leds;
        r[STAT_CAM_BIT] = e.cam;
      end
      OFS_PADDR: r[AW-1:0] = e.paddr;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // Synchronised trigger level and its rising edge.
  assign lvl = s_r.sync[1];
  assign rise = s_r.sync[1] & ~s_r.sync[2];
  assign mem_we = s_r.ph_act & s_r.ph_wr & (s_r.ph_a == OFS_PDATA);

  lsq_tick #(.DIV(DIV)) u_tick (
    .clk(hclk),
    .rst_n(hresetn),
    .clr(tick_clr),
    .tick(tick)
  );

  lsq_prog_mem #(.AW(AW), .DW(32)) u_mem (
    .clk(hclk),
    .we(mem_we),
    .waddr(s_r.paddr),
    .wdata(hwdata),
    .raddr(s_nxt.pa),
    .rdata(mem_rd)
  );

  // Sequencer, delay, fetch and bus logic.
  always_comb begin
    s_nxt = s_r;
    tick_clr = 1'b0;
    s_nxt.sync = {s_r.sync[1:0], trig_in};
    d = s_r.use_def ? dflt_val(s_r.pa) : mem_rd;
    dlim = s_r.dly_ms ? DLY_MAX_MS : DLY_MAX_US;
    go = (s_r.typ == TYPE_FREE) || (s_r.typ == TYPE_CONT && lvl) ||
         (s_r.typ == TYPE_ONESHOT && rise);
    last_frm = 4'(s_r.frm + 4'h1) >= s_r.nfrm;
    last_rep = 8'(s_r.rep + 8'h1) >= s_r.nrep;
    last_seq = 4'(s_r.seq + 4'h1) >= s_r.nseq;
    seq_done = last_frm && last_rep;
    rcp_done = seq_done && last_seq;
    // Whether the engine goes on after this frame.
    case (s_r.typ)
      TYPE_FREE: keep = 1'b1;
      TYPE_CONT: keep = !(rcp_done && !lvl);
      default: begin
        case (s_r.evt)
          EVT_RECIPE: keep = !rcp_done;
          EVT_SEQ: keep = !seq_done;
          default: keep = 1'b0;
        endcase
      end
    endcase
    case (s_r.st)
      ST_IDLE: begin
        if (go) begin
          tick_clr = 1'b1;
          if (s_r.dly_en && s_r.typ != TYPE_FREE) begin
            s_nxt.st = ST_DELAY;
            s_nxt.msub = 10'h000;
            s_nxt.dcnt = (s_r.dly < DLY_MIN) ? DLY_MIN : ((s_r.dly > dlim) ? dlim : s_r.dly);
          end else begin
            s_nxt = begin_fetch(s_nxt);
          end
        end
      end
      ST_DELAY: begin
        if (tick) begin
          s_nxt.msub = (s_r.dly_ms && s_r.msub != 10'(US_PER_MS - 10'h1)) ?
                       10'(s_r.msub + 10'h1) : 10'h000;
          if (!s_r.dly_ms || s_r.msub == 10'(US_PER_MS - 10'h1)) begin
            s_nxt.dcnt = 16'(s_r.dcnt - 16'h1);
            if (s_r.dcnt <= 16'h0001) begin
              s_nxt = begin_fetch(s_nxt);
            end
          end
        end
      end
      ST_FETCH: begin
        case (s_r.step)
          3'h0: begin
            s_nxt.nseq = cnt_clamp(d[HDR_CNT_LSB +: 4], MAX_SEQS);
            if (s_r.seq >= s_nxt.nseq) begin
              s_nxt.seq = 4'h0;
            end
          end
          3'h1: begin
            s_nxt.nfrm = cnt_clamp(d[HDR_CNT_LSB +: 4], MAX_FRAMES);
            s_nxt.nrep = (d[HDR_REP_LSB +: 8] == 8'h00) ? 8'h01 : d[HDR_REP_LSB +: 8];
            if (s_r.frm >= s_nxt.nfrm || s_r.rep >= s_nxt.nrep) begin
              s_nxt.frm = 4'h0;
              s_nxt.rep = 8'h00;
            end
          end
          3'h2: begin
            s_nxt.ftime = (d[30:0] < MIN_WIDTH_US) ? MIN_WIDTH_US :
                          ((d[30:0] > MAX_TIME_US) ? MAX_TIME_US : d[30:0]);
          end
          LAST_STEP: s_nxt.cw = clamp_w(d[30:0], s_r.ftime);
          default: s_nxt.sw[2'(s_r.step - 3'h3)] = clamp_w(d[30:0], s_r.ftime);
        endcase
        if (s_r.step == LAST_STEP) begin
          s_nxt.st = ST_RUN;
          s_nxt.el = 31'h0;
          tick_clr = 1'b1;
        end else begin
          s_nxt.step = 3'(s_r.step + 3'h1);
          s_nxt.pa = addr_of(s_nxt.step, s_nxt.rcp, s_nxt.seq, s_nxt.frm);
        end
      end
      ST_RUN: begin
        if (tick) begin
          s_nxt.el = 31'(s_r.el + 31'h1);
          if (s_nxt.el >= s_r.ftime) begin
            s_nxt.frm = last_frm ? 4'h0 : 4'(s_r.frm + 4'h1);
            s_nxt.rep = last_frm ? (last_rep ? 8'h00 : 8'(s_r.rep + 8'h1)) : s_r.rep;
            s_nxt.seq = seq_done ? (last_seq ? 4'h0 : 4'(s_r.seq + 4'h1)) : s_r.seq;
            s_nxt.st = ST_IDLE;
            if (keep) begin
              s_nxt = begin_fetch(s_nxt);
            end
          end
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    // Data phase of a write; a control write rewinds the program position.
    if (s_r.ph_act && s_r.ph_wr) begin
      case (s_r.ph_a)
        OFS_CTRL: begin
          s_nxt.typ = hwdata[CTRL_TYPE_LSB +: 2];
          s_nxt.evt = hwdata[CTRL_EVT_LSB +: 2];
          s_nxt.dly_en = hwdata[CTRL_DLYEN_BIT];
          s_nxt.dly_ms = hwdata[CTRL_DLYMS_BIT];
          s_nxt.use_def = hwdata[CTRL_DEF_BIT];
          s_nxt.rcp = (hwdata[CTRL_RCP_LSB +: 3] >= MAX_RECIPES) ? 3'h0 :
                      hwdata[CTRL_RCP_LSB +: 3];
          s_nxt.seq = 4'h0;
          s_nxt.frm = 4'h0;
          s_nxt.rep = 8'h00;
        end
        OFS_DELAY: s_nxt.dly = hwdata[15:0];
        OFS_PADDR: s_nxt.paddr = hwdata[AW-1:0];
        OFS_PDATA: s_nxt.paddr = AW'(s_r.paddr + 1'b1);
        default: s_nxt.dly = s_r.dly;
      endcase
    end
    // Address phase; read data is taken from the updated view.
    s_nxt.ph_act = hsel && hready && htrans[1];
    s_nxt.ph_wr = hwrite;
    s_nxt.ph_a = haddr[7:0];
    if (hsel && hready && htrans[1] && !hwrite) begin
      s_nxt.hrdata = rd_mux(haddr[7:0], s_nxt);
    end
    // Outputs all switch on the same edge from one elapsed count.
    for (int k = 0; k < N_CH; k++) begin
      s_nxt.leds[k] = (s_nxt.st == ST_RUN) && (s_nxt.el < s_nxt.sw[k]);
    end
    s_nxt.cam = (s_nxt.st == ST_RUN) && (s_nxt.el < s_nxt.cw);
  end

  // State register; reset selects one-shot, recipe event and the built-in program.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.typ <= TYPE_ONESHOT;
      s_r.evt <= EVT_RECIPE;
      s_r.use_def <= RST_USE_DEF;
      s_r.hready <= 1'b1;
      s_r.nseq <= 4'h1;
      s_r.nfrm <= 4'h1;
      s_r.nrep <= 8'h01;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register.
  assign hrdata = s_r.hrdata;
  assign hreadyout = s_r.hready;
  assign hresp = s_r.hresp;
  assign lighting_channel_outputs = s_r.leds;
  assign cam_trig_out = s_r.cam;

  // Cycles the camera output has stood high.
  logic [15:0] hi_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_r <= 16'h0000;
    end else if (!s_r.cam) begin
      hi_r <= 16'h0000;
    end else if (hi_r != 16'hFFFF) begin
      hi_r <= 16'(hi_r + 16'h1);
    end
  end

  property p_dflt_shape;
    @(posedge hclk) disable iff (!hresetn)
    (s_r.st == ST_RUN && s_r.use_def) |-> (s_r.nfrm == DEF_FRAMES && s_r.nseq == 4'h1);
  endproperty
  a_dflt_shape: assert property (p_dflt_shape) else $error("Default program shape wrong.");

  property p_dflt_time;
    @(posedge hclk) disable iff (!hresetn)
    (s_r.st == ST_FETCH && s_r.step == LAST_STEP && s_r.use_def) |=>
      (s_r.ftime == DEF_FRAME_US && s_r.cw == DEF_CAM_US && $countones(s_r.leds) == 1);
  endproperty
  a_dflt_time: assert property (p_dflt_time) else $error("Default frame timing wrong.");

  property p_min_width;
    @(posedge hclk) disable iff (!hresetn)
    $fell(s_r.cam) |-> hi_r >= 16'(int'(MIN_WIDTH_US) * DIV);
  endproperty
  a_min_width: assert property (p_min_width) else $error("Camera pulse too short.");

  property p_start_lat;
    @(posedge hclk) disable iff (!hresetn)
    (s_r.st == ST_IDLE && s_r.typ == TYPE_ONESHOT && !s_r.dly_en && rise) |->
      ##[1:12] (s_r.st == ST_RUN);
  endproperty
  a_start_lat: assert property (p_start_lat) else $error("Frame start too late.");

  property p_edge_align;
    @(posedge hclk) disable iff (!hresetn)
    $rose(s_r.leds != '0 || s_r.cam) |-> ($past(s_r.st) == ST_FETCH && s_r.el == 31'h0);
  endproperty
  a_edge_align: assert property (p_edge_align) else $error("Output edge off frame start.");

  property p_strobe_short;
    @(posedge hclk) disable iff (!hresetn)
    (s_r.st == ST_RUN && s_r.el == 31'(s_r.ftime - 31'h1)) |-> s_r.leds == '0;
  endproperty
  a_strobe_short: assert property (p_strobe_short) else $error("Strobe spans frame.");

  property p_cam_short;
    @(posedge hclk) disable iff (!hresetn)
    (s_r.st == ST_RUN && s_r.el == 31'(s_r.ftime - 31'h1)) |-> !s_r.cam;
  endproperty
  a_cam_short: assert property (p_cam_short) else $error("Camera pulse spans frame.");

  property p_cont_stop;
    @(posedge hclk) disable iff (!hresetn)
    (s_r.st == ST_IDLE && s_r.typ == TYPE_CONT && !lvl) |=> s_r.st == ST_IDLE;
  endproperty
  a_cont_stop: assert property (p_cont_stop) else $error("Continuous ran without trigger.");

  property p_free_run;
    @(posedge hclk) disable iff (!hresetn)
    (s_r.st == ST_IDLE && s_r.typ == TYPE_FREE) |=> s_r.st == ST_FETCH;
  endproperty
  a_free_run: assert property (p_free_run) else $error("Free-run did not restart.");

  property p_ignore_trig;
    @(posedge hclk) disable iff (!hresetn)
    (s_r.st == ST_RUN && s_r.typ == TYPE_ONESHOT && rise && !tick) |=> s_r.st == ST_RUN;
  endproperty
  a_ignore_trig: assert property (p_ignore_trig) else $error("Trigger disturbed a run.");
endmodule
`default_nettype wire

// ### testbench/lsq_partner.sv
`timescale 1ns/100ps
`default_nettype none
module lsq_partner #(
  parameter int DIV = 10
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Trigger requests from the bench
  input wire logic fire,
  input wire logic level,
  output logic trig_in,
  // Camera side
  input wire logic cam,
  output logic [15:0] cam_pulses,
  output logic [31:0] cam_w
);
  logic [15:0] gap_r;
  logic [31:0] run_r;

  // Each pulse lasts 20 cycles; a request inside the spacing window is dropped.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_r <= 16'h0000;
      trig_in <= 1'b0;
    end else begin
      if (fire && gap_r == 16'h0000) begin
        gap_r <= 16'(100 * DIV);
      end else if (gap_r != 16'h0000) begin
        gap_r <= gap_r - 16'h0001;
      end
      trig_in <= level || (gap_r > 16'(100 * DIV - 20));
    end
  end

  // The camera times every trigger pulse it receives.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r <= 32'h0;
      cam_w <= 32'h0;
      cam_pulses <= 16'h0;
    end else if (cam) begin
      run_r <= run_r + 32'h1;
    end else if (run_r != 32'h0) begin
      cam_w <= run_r;
      cam_pulses <= cam_pulses + 16'h1;
      run_r <= 32'h0;
    end
  end
endmodule
`default_nettype wire

// ### testbench/light_strobe_sequencer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module light_strobe_sequencer_bench;
  import lsq_pkg::*;
  localparam int DIV = 10;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic fire = 1'b0;
  logic level = 1'b0;
  logic trig_in;
  logic [3:0] leds;
  logic cam;
  logic [15:0] cam_pulses;
  logic [31:0] cam_w;
  logic [31:0] rd;
  logic [15:0] p;
  int lat;
  int n_fail = 0;
  int compares = 0;
  int hi [5];
  logic [31:0] prog_w [14] = '{32'h12C, 32'h96, 32'h32, 32'h0, 32'h190, 32'h78, 32'h102,
    32'h1, 32'hC8, 32'h64, 32'h64, 32'h64, 32'h64, 32'h64};

  // Clock of 4 ns.
  always #2 hclk = ~hclk;

  lsq_top #(.DIV(DIV)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trig_in(trig_in),
    .lighting_channel_outputs(leds), .cam_trig_out(cam));

  lsq_partner #(.DIV(DIV)) far (.hclk(hclk), .hresetn(hresetn), .fire(fire), .level(level),
    .trig_in(trig_in), .cam(cam), .cam_pulses(cam_pulses), .cam_w(cam_w));

  // Totals of high cycles per output since the last clear.
  always @(posedge hclk) begin
    for (int i = 0; i < 4; i++) hi[i] += int'(leds[i]);
    hi[4] += int'(cam);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One AHB transfer: address phase, then data phase.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic idle();
    int n;
    n = 0;
    do begin
      xfer(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 5000);
    chk(32'(n < 5000), 32'h1);
  endtask

  task automatic pulse();
    fire <= 1'b1;
    @(posedge hclk);
    fire <= 1'b0;
  endtask

  // Fires a trigger and waits for the first frame to start.
  task automatic go(input logic [3:0] exp_leds);
    hi = '{default: 0};
    p = cam_pulses;
    lat = 0;
    pulse();
    while (cam !== 1'b1 && lat < 20000) begin
      @(posedge hclk);
      lat++;
    end
    chk(leds, exp_leds);
  endtask

  // Built-in program runs after reset, then a reset in mid-frame stops it cleanly.
  task automatic t_default();
    go(4'h1);
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk({rd[28:24], rd[0]}, 6'h23);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({cam, leds}, 5'h00);
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    $display("test built-in program and reset done");
  endtask

  task automatic t_reset();
    xfer(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h40);
    chk(32'(hresp), 32'h0);
    xfer(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 14; i++) begin
      if (i == 0) xfer(1'b1, OFS_PADDR, 32'h0);
      xfer(1'b1, OFS_PDATA, prog_w[i]);
    end
    xfer(1'b0, OFS_PDATA, 32'h0);
    chk(rd, 32'h0);
    $display("test reset and program done");
  endtask

  task automatic t_frame();
    xfer(1'b1, OFS_CTRL, 32'h8);
    go(4'hB);
    chk(32'(lat <= 50 * DIV), 32'h1);
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk({rd[28:24], rd[0]}, 6'h37);
    repeat (1100) @(posedge hclk);
    pulse();
    idle();
    chk(hi[0], prog_w[1] * DIV);
    chk(hi[1], MIN_WIDTH_US * DIV);
    chk(hi[2], 32'h0);
    chk(hi[3], (prog_w[0] - 1) * DIV);
    chk(cam_w, prog_w[5] * DIV);
    chk(32'(cam_pulses - p), 32'h1);
    go(4'hF);
    idle();
    for (int i = 0; i < 5; i++) chk(hi[i], prog_w[9 + i] * DIV);
    go(4'hB);
    idle();
    chk(hi[0], prog_w[1] * DIV);
    $display("test frame event done");
  endtask

  task automatic t_modes();
    for (int e = 0; e < 2; e++) begin
      xfer(1'b1, OFS_CTRL, 32'(4 - 4 * e));
      go(4'hB);
      idle();
      chk(32'(cam_pulses - p), 32'h2);
    end
    xfer(1'b1, OFS_DELAY, 32'h1);
    xfer(1'b0, OFS_DELAY, 32'h0);
    chk(rd, 32'h1);
    xfer(1'b1, OFS_DELAY, 32'h5);
    xfer(1'b1, OFS_CTRL, 32'h18);
    go(4'hB);
    chk(32'(lat >= 5 * DIV && lat <= 55 * DIV), 32'h1);
    idle();
    $display("test events and delay done");
  endtask

  task automatic t_loops();
    xfer(1'b1, OFS_CTRL, 32'h1);
    p = cam_pulses;
    level <= 1'b1;
    repeat (6000) @(posedge hclk);
    level <= 1'b0;
    idle();
    chk(32'(cam_pulses - p), 32'h4);
    xfer(1'b1, OFS_CTRL, 32'h2);
    p = cam_pulses;
    repeat (11000) @(posedge hclk);
    chk(32'(cam_pulses - p >= 16'h3), 32'h1);
    xfer(1'b1, OFS_CTRL, 32'h0);
    idle();
    $display("test continuous and free-run done");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence after a reset of three cycles.
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_default();
    t_reset();
    t_frame();
    t_modes();
    t_loops();
    end_of_test();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (90000) @(posedge hclk);
    n_fail++;
    end_of_test();
  end
endmodule
`default_nettype wire
